/* design/cpa_alloc_ctrl.sv */
// Cache partition allocation control: tag store, per-partition tables, registers.
// Assumes requests arrive one per cycle on the same clock; no back-pressure.
`timescale 1ns/100ps
// Overview of operation
// - Request partition_id selects its control settings
// - Same partition_id shares one control set
// - Feature register advertises implemented controls
// - Each map bit gates one portion
// - Map width equals readable portion count
// - Victims only in enabled portions
// - Shared portions usable by all enabled partitions
// - Map change affects only later allocations
// - Stranded lines stay usable, replaceable
// - Lookup hits regardless of partition
// - At capacity limit, no usage growth
// - Capacity enforced by self-replacement or skip
// - Map and capacity apply together
// - Limit is fraction, 0xffff whole cache
// - Keep top limit bits, low read zero
// - Enforce within one implemented unit
module cpa_alloc_ctrl
   import cpa_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic reqValid,
   input wire cpa_req_t req,
   input wire logic invValid,
   input wire logic [CPA_SETS_W-1:0] invSet,
   input wire logic [CPA_TAG_W-1:0] invTag,
   output logic respValid,
   output cpa_resp_t resp,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata
);
   // Line store: one way per portion
   logic lineValid_reg [CPA_NUM_SETS][CPA_PORTIONS];
   logic lineValid_next [CPA_NUM_SETS][CPA_PORTIONS];
   logic [CPA_TAG_W-1:0] lineTag_reg [CPA_NUM_SETS][CPA_PORTIONS];
   logic [CPA_TAG_W-1:0] lineTag_next [CPA_NUM_SETS][CPA_PORTIONS];
   logic [CPA_PART_W-1:0] lineOwner_reg [CPA_NUM_SETS][CPA_PORTIONS];
   logic [CPA_PART_W-1:0] lineOwner_next [CPA_NUM_SETS][CPA_PORTIONS];
   // Per-partition control tables and occupancy
   logic [CPA_PORTIONS-1:0] allowMap_reg [CPA_NUM_PART];
   logic [CPA_PORTIONS-1:0] allowMap_next [CPA_NUM_PART];
   logic [CPA_FRAC_IMPL-1:0] maxCap_reg [CPA_NUM_PART];
   logic [CPA_FRAC_IMPL-1:0] maxCap_next [CPA_NUM_PART];
   logic [CPA_OCC_W:0] occ_reg [CPA_NUM_PART];
   logic [CPA_OCC_W:0] occ_next [CPA_NUM_PART];
   // Selector, round-robin pointer, answer and read data
   logic [CPA_PART_W-1:0] partSel_reg, partSel_next;
   logic [2:0] rr_reg, rr_next;
   logic respValid_reg, respValid_next;
   cpa_resp_t resp_reg, resp_next;
   logic [31:0] rdata_reg, rdata_next;

   // Lines the stored limit allows; one unit of slack, capped at whole cache
   function automatic logic [CPA_OCC_W:0] capLines(input logic [CPA_FRAC_IMPL-1:0] frac);
      logic [CPA_OCC_W+CPA_FRAC_IMPL:0] prod;
      prod = ((CPA_OCC_W+CPA_FRAC_IMPL+1)'(frac) + 1'b1) * (CPA_OCC_W+CPA_FRAC_IMPL+1)'(CPA_LINES);
      return (CPA_OCC_W+1)'(prod >> CPA_FRAC_IMPL);
   endfunction : capLines

   // Hit detection across every way, partition ignored
   logic hit;
   logic [2:0] hitWay;
   logic [CPA_PORTIONS-1:0] validMask, ownMask, allowMask;
   logic atCap;
   always_comb begin
      hit = 1'b0;
      hitWay = 3'h0;
      validMask = '0;
      ownMask = '0;
      for (int w = 0; w < CPA_PORTIONS; w++) begin
         validMask[w] = lineValid_reg[req.setIdx][w];
         ownMask[w] = lineValid_reg[req.setIdx][w] && lineOwner_reg[req.setIdx][w] == req.partitionId;
         if (lineValid_reg[req.setIdx][w] && lineTag_reg[req.setIdx][w] == req.tag) begin
            hit = 1'b1;
            hitWay = 3'(w);
         end
      end
      // capacity check, floor of stored fraction plus one unit
      atCap = occ_reg[req.partitionId] >= capLines(maxCap_reg[req.partitionId]);
      // map and capacity combined; at cap only own lines replaced
      // any partition with the bit may use the portion
      allowMask = allowMap_reg[req.partitionId] & (atCap ? ownMask : {CPA_PORTIONS{1'b1}});
   end

   logic vicFound;
   logic [2:0] vicWay;
   cpa_victim_pick u_pick (
      .allowMask(allowMask),
      .validMask(validMask),
      .rrPtr(rr_reg),
      .found(vicFound),
      .victim(vicWay)
   );

   // Next state of store, tables and registers
   always_comb begin
      logic [CPA_PART_W-1:0] oldOwner;
      oldOwner = '0;
      lineValid_next = lineValid_reg;
      lineTag_next = lineTag_reg;
      lineOwner_next = lineOwner_reg;
      allowMap_next = allowMap_reg;
      maxCap_next = maxCap_reg;
      occ_next = occ_reg;
      partSel_next = partSel_reg;
      rr_next = rr_reg;
      respValid_next = reqValid;
      resp_next = '0;
      rdata_next = '0;
      // Invalidation: lines in disabled portions leave only this way or by eviction
      if (invValid) begin
         for (int w = 0; w < CPA_PORTIONS; w++) begin
            if (lineValid_reg[invSet][w] && lineTag_reg[invSet][w] == invTag) begin
               lineValid_next[invSet][w] = 1'b0;
               occ_next[lineOwner_reg[invSet][w]] = occ_next[lineOwner_reg[invSet][w]] - 1'b1;
            end
         end
      end
      if (reqValid) begin
         resp_next.hit = hit;
         resp_next.way = hitWay;
         if (!hit && req.allocate) begin
            if (vicFound) begin
               // install only; resident lines never moved
               // Seen after invalidation, so a line dropped this cycle is not counted twice
               if (lineValid_next[req.setIdx][vicWay]) begin
                  oldOwner = lineOwner_reg[req.setIdx][vicWay];
                  occ_next[oldOwner] = occ_next[oldOwner] - 1'b1;
               end
               lineValid_next[req.setIdx][vicWay] = 1'b1;
               lineTag_next[req.setIdx][vicWay] = req.tag;
               lineOwner_next[req.setIdx][vicWay] = req.partitionId;
               occ_next[req.partitionId] = occ_next[req.partitionId] + 1'b1;
               rr_next = 3'(vicWay + 3'h1);
               resp_next.allocated = 1'b1;
               resp_next.way = vicWay;
            end else begin
               // not allocating when nothing is allowed
               resp_next.blocked = 1'b1;
            end
         end
      end
      // Register writes
      if (regWr) begin
         if (regAddr == CPA_OFF_PART_SEL) begin
            partSel_next = regWdata[CPA_PART_W-1:0];
         end else if (regAddr == CPA_OFF_ALLOW_MAP) begin
            allowMap_next[partSel_reg] = regWdata[CPA_PORTIONS-1:0];
         end else if (regAddr == CPA_OFF_MAX_CAP) begin
            maxCap_next[partSel_reg] = regWdata[CPA_FRAC_W-1 -: CPA_FRAC_IMPL];
         end
      end
      // Register reads; unmapped reads return zero
      if (regRd) begin
         if (regAddr == CPA_OFF_FEATURE_ID) begin
            rdata_next[CPA_FEAT_PORTION_BIT] = 1'b1;
            rdata_next[CPA_FEAT_MAXCAP_BIT] = 1'b1;
         end else if (regAddr == CPA_OFF_PORTION_CNT) begin
            rdata_next = 32'(CPA_PORTIONS);
         end else if (regAddr == CPA_OFF_PART_SEL) begin
            rdata_next = 32'(partSel_reg);
         end else if (regAddr == CPA_OFF_ALLOW_MAP) begin
            rdata_next = 32'(allowMap_reg[partSel_reg]);
         end else if (regAddr == CPA_OFF_MAX_CAP) begin
            rdata_next = {16'h0000, maxCap_reg[partSel_reg], {(CPA_FRAC_W-CPA_FRAC_IMPL){1'b0}}};
         end else if (regAddr == CPA_OFF_OCCUPANCY) begin
            rdata_next = 32'(occ_reg[partSel_reg]);
         end
      end
   end

   // Registers only
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int s = 0; s < CPA_NUM_SETS; s++) begin
            for (int w = 0; w < CPA_PORTIONS; w++) begin
               lineValid_reg[s][w] <= 1'b0;
               lineTag_reg[s][w] <= '0;
               lineOwner_reg[s][w] <= '0;
            end
         end
         for (int p = 0; p < CPA_NUM_PART; p++) begin
            allowMap_reg[p] <= CPA_MAP_RESET;
            maxCap_reg[p] <= CPA_CAP_RESET[CPA_FRAC_W-1 -: CPA_FRAC_IMPL];
            occ_reg[p] <= '0;
         end
         partSel_reg <= '0;
         rr_reg <= '0;
         respValid_reg <= 1'b0;
         resp_reg <= '0;
         rdata_reg <= '0;
      end else begin
         lineValid_reg <= lineValid_next;
         lineTag_reg <= lineTag_next;
         lineOwner_reg <= lineOwner_next;
         allowMap_reg <= allowMap_next;
         maxCap_reg <= maxCap_next;
         occ_reg <= occ_next;
         partSel_reg <= partSel_next;
         rr_reg <= rr_next;
         respValid_reg <= respValid_next;
         resp_reg <= resp_next;
         rdata_reg <= rdata_next;
      end
   end

   assign respValid = respValid_reg;
   assign resp = resp_reg;
   assign regRdata = rdata_reg;

   // Allocation always lands in a way the map enables
   property p_alloc_in_map;
      @(posedge clk_sys) disable iff (rst)
      (reqValid && !hit && req.allocate && vicFound) |-> allowMap_reg[req.partitionId][vicWay];
   endproperty
   a_alloc_in_map: assert property (p_alloc_in_map) else $error("victim outside allowed portions");

   // A hit answer follows a hitting request one cycle later
   property p_hit_answer;
      @(posedge clk_sys) disable iff (rst)
      (reqValid && hit) |=> (respValid && resp.hit && !resp.allocated);
   endproperty
   a_hit_answer: assert property (p_hit_answer) else $error("hit not reported");

   // At the cap the partition cannot grow
   property p_cap_hold;
      @(posedge clk_sys) disable iff (rst)
      (reqValid && atCap && !invValid && !(regWr && regAddr == CPA_OFF_MAX_CAP))
         |=> occ_reg[$past(req.partitionId)] <= $past(occ_reg[req.partitionId]);
   endproperty
   a_cap_hold: assert property (p_cap_hold) else $error("partition grew past limit");

   // Allocation into a free way increments occupancy of requester
   property p_occ_inc;
      @(posedge clk_sys) disable iff (rst)
      (reqValid && !hit && req.allocate && vicFound && !invValid && !validMask[vicWay])
         |=> occ_reg[$past(req.partitionId)] == $past(occ_reg[req.partitionId]) + 1'b1;
   endproperty
   a_occ_inc: assert property (p_occ_inc) else $error("occupancy not incremented");

   // Limit read back has low bits zero
   property p_cap_read;
      @(posedge clk_sys) disable iff (rst)
      (regRd && regAddr == CPA_OFF_MAX_CAP) |=> regRdata[CPA_FRAC_W-CPA_FRAC_IMPL-1:0] == '0;
   endproperty
   a_cap_read: assert property (p_cap_read) else $error("low limit bits nonzero");

   // Map write then read returns the value for the same selection
   property p_map_rb;
      @(posedge clk_sys) disable iff (rst)
      (regWr && regAddr == CPA_OFF_ALLOW_MAP) ##1 (regRd && regAddr == CPA_OFF_ALLOW_MAP)
         |=> regRdata == 32'($past(regWdata[CPA_PORTIONS-1:0], 2));
   endproperty
   a_map_rb: assert property (p_map_rb) else $error("map read back wrong");

   // Portion count reads the map width
   property p_count;
      @(posedge clk_sys) disable iff (rst)
      (regRd && regAddr == CPA_OFF_PORTION_CNT) |=> regRdata == 32'(CPA_PORTIONS);
   endproperty
   a_count: assert property (p_count) else $error("portion count wrong");

   // Feature register shows both controls
   property p_feat;
      @(posedge clk_sys) disable iff (rst)
      (regRd && regAddr == CPA_OFF_FEATURE_ID) |=> (regRdata[CPA_FEAT_PORTION_BIT] && regRdata[CPA_FEAT_MAXCAP_BIT]);
   endproperty
   a_feat: assert property (p_feat) else $error("feature bits missing");
endmodule : cpa_alloc_ctrl

/* inc/cpa_pkg.sv */
// Package for cache partition allocation control: register map, widths, structs.
// Assumes one synchronous clock domain and a plain strobe register port.
package cpa_pkg;
   // Geometry of the shared cache
   localparam int CPA_PART_W = 3;
   localparam int CPA_NUM_PART = 8;
   localparam int CPA_PORTIONS = 8;
   localparam int CPA_WAYS_PER_PORTION = 1;
   localparam int CPA_SETS_W = 4;
   localparam int CPA_NUM_SETS = 16;
   localparam int CPA_TAG_W = 12;
   localparam int CPA_LINES = 128;
   localparam int CPA_OCC_W = 8;
   // Capacity limit: 16-bit fraction, top bits implemented
   localparam int CPA_FRAC_W = 16;
   localparam int CPA_FRAC_IMPL = 8;
   localparam logic [15:0] CPA_FRAC_ONE = 16'hffff;
   // Register offsets (byte addresses)
   localparam logic [7:0] CPA_OFF_FEATURE_ID = 8'h00;
   localparam logic [7:0] CPA_OFF_PORTION_CNT = 8'h04;
   localparam logic [7:0] CPA_OFF_PART_SEL = 8'h08;
   localparam logic [7:0] CPA_OFF_ALLOW_MAP = 8'h0c;
   localparam logic [7:0] CPA_OFF_MAX_CAP = 8'h10;
   localparam logic [7:0] CPA_OFF_OCCUPANCY = 8'h14;
   // Feature bits
   localparam int CPA_FEAT_PORTION_BIT = 0;
   localparam int CPA_FEAT_MAXCAP_BIT = 1;
   // Reset values of the control tables
   localparam logic [CPA_PORTIONS-1:0] CPA_MAP_RESET = 8'hff;
   localparam logic [15:0] CPA_CAP_RESET = 16'hffff;

   // Incoming request from an upstream requester
   typedef struct packed {
      logic [CPA_PART_W-1:0] partitionId;
      logic [CPA_SETS_W-1:0] setIdx;
      logic [CPA_TAG_W-1:0] tag;
      logic allocate;
   } cpa_req_t;

   // Lookup and allocation answer
   typedef struct packed {
      logic hit;
      logic allocated;
      logic blocked;
      logic [2:0] way;
   } cpa_resp_t;
endpackage : cpa_pkg

/* design/cpa_victim_pick.sv */
// Victim picker: first free way among allowed ways, else round robin among them.
// Assumes allowed mask is already the product of map and capacity policy.
`timescale 1ns/100ps
module cpa_victim_pick
   import cpa_pkg::*;
(
   input wire logic [CPA_PORTIONS-1:0] allowMask,
   input wire logic [CPA_PORTIONS-1:0] validMask,
   input wire logic [2:0] rrPtr,
   output logic found,
   output logic [2:0] victim
);
   // Scan starting at the round-robin pointer, free ways first
   always_comb begin
      logic [2:0] idx;
      idx = 3'h0;
      found = 1'b0;
      victim = 3'h0;
      for (int i = 0; i < CPA_PORTIONS; i++) begin
         idx = 3'(rrPtr + 3'(i));
         if (!found && allowMask[idx] && !validMask[idx]) begin
            found = 1'b1;
            victim = idx;
         end
      end
      for (int i = 0; i < CPA_PORTIONS; i++) begin
         idx = 3'(rrPtr + 3'(i));
         if (!found && allowMask[idx]) begin
            found = 1'b1;
            victim = idx;
         end
      end
   end
endmodule : cpa_victim_pick

/* test/cpa_requester_model.sv */
// Upstream requester model: issues partition-tagged lookups and invalidations.
// Assumes the cache answers one cycle after each request and never stalls.
`timescale 1ns/100ps
module cpa_requester_model
   import cpa_pkg::*;
(
   input wire logic clk_sys,
   output logic reqValid,
   output cpa_req_t req,
   output logic invValid,
   output logic [CPA_SETS_W-1:0] invSet,
   output logic [CPA_TAG_W-1:0] invTag
);
   // Quiet bus at time zero
   initial begin
      reqValid = 1'b0;
      req = '0;
      invValid = 1'b0;
      invSet = '0;
      invTag = '0;
   end

   // One request: held for exactly one sampling edge, then the fields are
   // scrambled so a design that samples late cannot see stale good values
   task automatic issue(input logic [2:0] pid, input logic [3:0] setIdx, input logic [11:0] tag,
                        input logic alloc);
      @(posedge clk_sys);
      reqValid <= 1'b1;
      req <= '{partitionId: pid, setIdx: setIdx, tag: tag, allocate: alloc};
      @(posedge clk_sys);
      reqValid <= 1'b0;
      req <= ~req;
   endtask : issue

   // One invalidation pulse naming a line of any partition
   task automatic inval(input logic [3:0] setIdx, input logic [11:0] tag);
      @(posedge clk_sys);
      invValid <= 1'b1;
      invSet <= setIdx;
      invTag <= tag;
      @(posedge clk_sys);
      invValid <= 1'b0;
      invSet <= ~invSet;
      invTag <= ~invTag;
   endtask : inval
endmodule : cpa_requester_model

/* test/cpa_alloc_ctrl_tb_top.sv */
// Self-checking bench for the partition allocation control block.
// Assumes single-way portions so every install lands in a predictable way.
`timescale 1ns/100ps
module cpa_alloc_ctrl_tb_top
   import cpa_pkg::*;
;
   logic clk_sys, rst; // Clock and synchronous reset
   logic reqValid, invValid, respValid; // Request side strobes
   cpa_req_t req; // Request fields from the model
   cpa_resp_t resp; // Registered answer
   logic [CPA_SETS_W-1:0] invSet; // Line to drop
   logic [CPA_TAG_W-1:0] invTag;
   logic [7:0] regAddr; // Register port
   logic [31:0] regWdata, regRdata;
   logic regWr, regRd;
   int nFail = 0; // Mismatch count
   int checksDone = 0; // Comparison count

   // 40 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   cpa_requester_model mdl (.clk_sys(clk_sys), .reqValid(reqValid), .req(req), .invValid(invValid),
      .invSet(invSet), .invTag(invTag));

   cpa_alloc_ctrl dut (.clk_sys(clk_sys), .rst(rst), .reqValid(reqValid), .req(req), .invValid(invValid),
      .invSet(invSet), .invTag(invTag), .respValid(respValid), .resp(resp), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));

   // Word comparison
   task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         nFail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chkWord

   // Answer comparison; way is ignored where no line is installed or hit
   task automatic chkResp(input logic vld, input cpa_resp_t got, input cpa_resp_t exp, input logic useWay);
      logic [6:0] g;
      logic [6:0] e;
      g = {vld, got.hit, got.allocated, got.blocked, useWay ? got.way : 3'h0};
      e = {1'b1, exp.hit, exp.allocated, exp.blocked, useWay ? exp.way : 3'h0};
      checksDone++;
      if (g !== e) begin
         nFail++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chkResp

   // Verdict and end of run
   task automatic reportAndStop();
      $display("checks=%0d mismatches=%0d", checksDone, nFail);
      if (nFail == 0 && checksDone > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : reportAndStop

   // Single-cycle register write
   task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask : regWrite

   // Register read: data stands only in the cycle after the strobe
   task automatic regRead(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRd <= 1'b0;
      @(negedge clk_sys);
      chkWord(regRdata, exp);
      @(negedge clk_sys);
      chkWord(regRdata, 32'h0);
   endtask : regRead

   // Write then read of one register with no gap between the strobes
   task automatic wrThenRd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
      @(posedge clk_sys);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk_sys);
      regWr <= 1'b0;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      @(negedge clk_sys);
      chkWord(regRdata, exp);
   endtask : wrThenRd

   // Select a partition first, then its controls
   task automatic progPart(input logic [2:0] pid, input logic [7:0] map, input logic [15:0] cap);
      regWrite(CPA_OFF_PART_SEL, {29'h0, pid});
      regWrite(CPA_OFF_ALLOW_MAP, {24'h0, map});
      regWrite(CPA_OFF_MAX_CAP, {16'h0, cap});
   endtask : progPart

   // Occupancy of one partition
   task automatic occ(input logic [2:0] pid, input logic [31:0] exp);
      regWrite(CPA_OFF_PART_SEL, {29'h0, pid});
      regRead(CPA_OFF_OCCUPANCY, exp);
   endtask : occ

   // One request and its answer a cycle later; e = {hit, allocated, blocked, way}
   task automatic doReq(input logic [2:0] pid, input logic [3:0] s, input logic [11:0] t, input logic al,
                        input logic [5:0] e, input logic useWay);
      mdl.issue(pid, s, t, al);
      @(negedge clk_sys);
      chkResp(respValid, resp, cpa_resp_t'(e), useWay);
   endtask : doReq

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk_sys);
      nFail++;
      reportAndStop();
   end

   // Main sequence
   initial begin
      rst = 1'b1;
      regAddr = 8'h00;
      regWdata = 32'h0;
      regWr = 1'b0;
      regRd = 1'b0;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      regRead(CPA_OFF_FEATURE_ID, 32'h3);
      regWrite(CPA_OFF_FEATURE_ID, 32'h0);
      regRead(CPA_OFF_FEATURE_ID, 32'h3);
      regRead(CPA_OFF_PORTION_CNT, 32'h8);
      regRead(8'h3c, 32'h0);
      regRead(CPA_OFF_ALLOW_MAP, 32'hff);
      regRead(CPA_OFF_MAX_CAP, 32'hff00);
      progPart(3'h2, 8'h01, 16'h07ae);
      regRead(CPA_OFF_PART_SEL, 32'h2);
      regRead(CPA_OFF_ALLOW_MAP, 32'h01);
      regRead(CPA_OFF_MAX_CAP, 32'h0700);
      wrThenRd(CPA_OFF_ALLOW_MAP, 32'h3c, 32'h3c);
      wrThenRd(CPA_OFF_ALLOW_MAP, 32'h01, 32'h01);
      wrThenRd(CPA_OFF_MAX_CAP, 32'h0851, 32'h0800);
      regWrite(CPA_OFF_MAX_CAP, 32'hffff);
      regRead(CPA_OFF_MAX_CAP, 32'hff00);
      doReq(3'h2, 4'h0, 12'h001, 1'b1, 6'b010_000, 1'b1);
      doReq(3'h2, 4'h0, 12'h002, 1'b1, 6'b010_000, 1'b1);
      doReq(3'h5, 4'h0, 12'h002, 1'b0, 6'b100_000, 1'b1);
      occ(3'h2, 32'h1);
      progPart(3'h3, 8'h02, 16'hffff);
      doReq(3'h3, 4'h0, 12'h003, 1'b1, 6'b010_001, 1'b1);
      progPart(3'h4, 8'h01, 16'hffff);
      doReq(3'h4, 4'h0, 12'h004, 1'b1, 6'b010_000, 1'b1);
      occ(3'h2, 32'h0);
      occ(3'h4, 32'h1);
      progPart(3'h3, 8'h04, 16'hffff);
      doReq(3'h3, 4'h0, 12'h003, 1'b0, 6'b100_001, 1'b1);
      progPart(3'h4, 8'h02, 16'hffff);
      doReq(3'h4, 4'h0, 12'h005, 1'b1, 6'b010_001, 1'b1);
      occ(3'h3, 32'h0);
      progPart(3'h6, 8'h08, 16'h0200);
      doReq(3'h6, 4'h1, 12'h007, 1'b1, 6'b010_011, 1'b1);
      doReq(3'h6, 4'h2, 12'h008, 1'b1, 6'b001_000, 1'b0);
      doReq(3'h6, 4'h1, 12'h009, 1'b1, 6'b010_011, 1'b1);
      occ(3'h6, 32'h1);
      mdl.inval(4'h1, 12'h009);
      occ(3'h6, 32'h0);
      progPart(3'h7, 8'h00, 16'hffff);
      doReq(3'h7, 4'h3, 12'h00a, 1'b1, 6'b001_000, 1'b0);
      progPart(3'h7, 8'hff, 16'h0000);
      doReq(3'h7, 4'h3, 12'h00a, 1'b1, 6'b001_000, 1'b0);
      progPart(3'h5, 8'h10, 16'h0100);
      doReq(3'h5, 4'h4, 12'h00b, 1'b1, 6'b010_100, 1'b1);
      doReq(3'h5, 4'h5, 12'h00c, 1'b1, 6'b001_000, 1'b0);
      reportAndStop();
   end
endmodule : cpa_alloc_ctrl_tb_top
